// [rtl/ips_regs.svh]
// Register offsets, field positions, reset values and counts of the interrupt priority block.
`ifndef IPS_REGS_SVH
`define IPS_REGS_SVH
// ----------------------------------------------------------------------------
// Contract
// - Status bits 11:8 read the new CPU priority level, 0 to 11.
// - Status bits 6:0 read the pending vector code; code 0 is vector 8.
// - The largest pending-vector code stands for vector 135.
// - Status bits 15:12 and 7 read zero; all fields reset to zero.
// - With nesting disabled no user interrupt preempts a handler already running; traps still do.
// - Every user source priority resets to level 4.
// - A source reaches the core only while its enable bit is set.
// - Entry never clears a source flag; a flag still set is taken again.
// - Return restores the stacked low status byte and previous CPU level.
// - Trap flags stay set until software clears them and re-enter the handler.
// - CPU level 7 in the low status byte blocks all user interrupts.
// - Trap sources at levels 8 to 11 are masked only by a running trap at an equal or higher level.
// - Timed disable masks levels 1 to 6 for its period; level 7 still interrupts.
// - Several enabled sources may share one non-zero priority and all get served.
// - Priority code 000 disables a source; codes 1 to 7 are levels, 7 highest.
// ----------------------------------------------------------------------------

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define IPS_OFF_STATUS   12'h000
`define IPS_OFF_CTRL1    12'h004
`define IPS_OFF_FLAG     12'h008
`define IPS_OFF_ENABLE   12'h00C
`define IPS_OFF_PRIO     12'h010
`define IPS_OFF_SRL      12'h014
`define IPS_OFF_TIMED_DISABLE_INSTR     12'h018

// ----------------------------------------------------------------------------
// Fields, reset values and counts
// ----------------------------------------------------------------------------
`define IPS_ADDR_W       12
`define IPS_DATA_W       32
`define IPS_ILR_MSB      11
`define IPS_ILR_LSB      8
`define IPS_VEC_MSB      6
`define IPS_NESTING_DISABLE_BIT   15
`define IPS_SRL_LVL_MSB  7
`define IPS_SRL_LVL_LSB  5
`define IPS_SRL_LOW_MSB  4
`define IPS_PRIO_W       3
`define IPS_PRIO_RESET   3'h4
`define IPS_PRIO_OFF     3'h0
`define IPS_USER_TOP     3'h7
`define IPS_TRAP_BASE    4'h8
`define IPS_VEC_BASE     8
`define IPS_TIMED_DISABLE_INSTR_CW      14
`define IPS_NTRAP_MAX    4
`endif

// [rtl/ips_pkg.sv]
// Bus and core carrier types of the interrupt priority block.
package ips_pkg;
    `include "ips_regs.svh"

    typedef struct packed {
        logic                    psel;
        logic                    penable;
        logic                    pwrite;
        logic [`IPS_ADDR_W-1:0]  paddr;
        logic [`IPS_DATA_W-1:0]  pwdata;
    } ips_apb_req_s;

    typedef struct packed {
        logic                    pready;
        logic [`IPS_DATA_W-1:0]  prdata;
        logic                    pslverr;
    } ips_apb_rsp_s;

    typedef struct packed {
        logic                    req;
        logic                    is_trap;
        logic [1:0]              trap_idx;
        logic [`IPS_VEC_MSB:0]   code;
        logic [3:0]              level;
    } ips_core_req_s;

    typedef struct packed {
        logic                    ack;
        logic                    ret;
        logic                    timed_disable_instr;
        logic [`IPS_TIMED_DISABLE_INSTR_CW-1:0] timed_disable_instr_cnt;
    } ips_core_cmd_s;
endpackage

// [rtl/ips_arbiter.sv]
// Priority selection among user sources and trap sources.
`timescale 1ns/1ps
`include "ips_regs.svh"
module ips_arbiter #(
    parameter int NSRC  = 8,
    parameter int NTRAP = 4
) (
    input  wire logic [NSRC-1:0]             src_flag,
    input  wire logic [NSRC-1:0]             src_en,
    input  wire logic [`IPS_PRIO_W*NSRC-1:0] src_prio,
    input  wire logic [NTRAP-1:0]            trap_flag,
    input  wire logic [3:0]                  cpu_lvl,
    input  wire logic                        user_ok,
    input  wire logic                        timed_disable_instr_on,
    output ips_pkg::ips_core_req_s           best
);
    import ips_pkg::*;

    logic [`IPS_PRIO_W-1:0] eff [NSRC];

    // ------------------------------------------------------------------------
    // Effective level per source
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < NSRC; i++)
    begin : g_src
        logic [`IPS_PRIO_W-1:0] p;
        assign p = src_prio[`IPS_PRIO_W*i +: `IPS_PRIO_W];
        assign eff[i] = (src_flag[i] && src_en[i] && (p != `IPS_PRIO_OFF) && user_ok
                         && (!timed_disable_instr_on || p == `IPS_USER_TOP)) ? p : `IPS_PRIO_OFF;
    end

    // ------------------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------------------
    // Strict comparison keeps the lower index on a tie.
    always_comb
    begin
        best = '0;
        best.level = cpu_lvl;
        for (int i = 0; i < NSRC; i++)
        begin
            if ({1'b0, eff[i]} > best.level)
            begin
                best.req = 1'b1;
                best.level = {1'b0, eff[i]};
                best.code = 7'(i);
            end
        end
        for (int t = 0; t < NTRAP; t++)
        begin
            if (trap_flag[t] && (`IPS_TRAP_BASE + 4'(t)) > best.level)
            begin
                best.req = 1'b1;
                best.is_trap = 1'b1;
                best.trap_idx = 2'(t);
                best.level = `IPS_TRAP_BASE + 4'(t);
                best.code = '0;
            end
        end
    end
endmodule

// [rtl/ips_disable_timer.sv]
// Down counter that holds the timed disable window.
`timescale 1ns/1ps
`include "ips_regs.svh"
module ips_disable_timer #(
    parameter int CW = `IPS_TIMED_DISABLE_INSTR_CW
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          start,
    input  wire logic [CW-1:0] count,
    output logic               active,
    output logic [CW-1:0]      remaining
);
    import ips_pkg::*;

    typedef struct packed {
        logic [CW-1:0] left;
    } ips_timed_disable_instr_s;

    ips_timed_disable_instr_s st_r;
    ips_timed_disable_instr_s st_nxt;

    // A new start reloads the window with its count, so a back to back disable restarts it.
    always_comb
    begin
        st_nxt = st_r;
        if (start)
        begin
            st_nxt.left = count;
        end
        else if (st_r.left != '0)
        begin
            st_nxt.left = st_r.left - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign active = (st_r.left != '0);
    assign remaining = st_r.left;
endmodule

// [rtl/ips_top.sv]
// Interrupt priority controller with status, masking, nesting stack and APB registers.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ips_regs.svh"
module ips_top #(
    parameter int NSRC  = 8,
    parameter int NTRAP = 4,
    parameter int DEPTH = 8
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire ips_pkg::ips_apb_req_s  apb_req,
    output ips_pkg::ips_apb_rsp_s       apb_rsp,
    input  wire logic [NSRC-1:0]        src_event,
    input  wire logic [NTRAP-1:0]       trap_event,
    input  wire ips_pkg::ips_core_cmd_s core_cmd,
    output ips_pkg::ips_core_req_s      core_req
);
    import ips_pkg::*;

    // ------------------------------------------------------------------------
    // Local sizes and state
    // ------------------------------------------------------------------------
    localparam int DW = $clog2(DEPTH + 1);
    localparam int FW = 4 + `IPS_SRL_LOW_MSB + 1;
    localparam int PW = `IPS_PRIO_W * NSRC;

    typedef struct packed {
        logic [NSRC-1:0]          flag;
        logic [NSRC-1:0]          en;
        logic [PW-1:0]            prio;
        logic                     nesting_disable;
        logic [NTRAP-1:0]         trap;
        logic [3:0]               cpu_lvl;
        logic [`IPS_SRL_LOW_MSB:0] srl_low;
        logic [3:0]               new_cpu_priority_level;
        logic [`IPS_VEC_MSB:0]    vec;
        logic [DW-1:0]            depth;
        logic [FW*DEPTH-1:0]      stack;
        ips_core_req_s            pend;
        logic [`IPS_DATA_W-1:0]   prdata;
        logic                     pslverr;
    } ips_state_s;

    ips_state_s               st_r;
    ips_state_s               st_nxt;
    ips_core_req_s            best;
    logic                     timed_disable_instr_on;
    logic [`IPS_TIMED_DISABLE_INSTR_CW-1:0]  timed_disable_instr_left;
    logic                     user_ok;
    logic                     setup;
    logic                     wr_acc;
    logic                     hit;
    logic                     ack_taken;
    logic                     ret_taken;
    logic                     event_now;
    logic [`IPS_DATA_W-1:0]   rd;
    logic [NSRC-1:0]          flag_clr;
    logic [NTRAP-1:0]         trap_clr;
    logic [FW-1:0]            frame;
    logic [DW-1:0]            top_idx;

    // ------------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------------
    // Nesting is refused only for user sources, so traps stay live.
    assign user_ok = !(st_r.nesting_disable && st_r.depth != '0);

    ips_arbiter #(
        .NSRC  (NSRC),
        .NTRAP (NTRAP)
    ) u_arb (
        .src_flag  (st_r.flag),
        .src_en    (st_r.en),
        .src_prio  (st_r.prio),
        .trap_flag (st_r.trap),
        .cpu_lvl   (st_r.cpu_lvl),
        .user_ok   (user_ok),
        .timed_disable_instr_on   (timed_disable_instr_on),
        .best      (best)
    );

    ips_disable_timer #(
        .CW (`IPS_TIMED_DISABLE_INSTR_CW)
    ) u_timed_disable_instr (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (core_cmd.timed_disable_instr),
        .count     (core_cmd.timed_disable_instr_cnt),
        .active    (timed_disable_instr_on),
        .remaining (timed_disable_instr_left)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        setup = apb_req.psel && !apb_req.penable;
        wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
        rd = '0;
        hit = 1'b1;
        flag_clr = '0;
        trap_clr = '0;
        ack_taken = core_cmd.ack && st_r.pend.req;
        ret_taken = core_cmd.ret && !ack_taken && (st_r.depth != '0);
        top_idx = DW'(st_r.depth - 1'b1);
        frame = st_r.stack[top_idx*FW +: FW];

        // Read decode; unused bits stay zero.
        case (apb_req.paddr)
            `IPS_OFF_STATUS:
            begin
                rd[`IPS_ILR_MSB:`IPS_ILR_LSB] = st_r.new_cpu_priority_level;
                rd[`IPS_VEC_MSB:0] = st_r.vec;
            end
            `IPS_OFF_CTRL1:
            begin
                rd[`IPS_NESTING_DISABLE_BIT] = st_r.nesting_disable;
                rd[NTRAP-1:0] = st_r.trap;
            end
            `IPS_OFF_FLAG:
            begin
                rd[NSRC-1:0] = st_r.flag;
            end
            `IPS_OFF_ENABLE:
            begin
                rd[NSRC-1:0] = st_r.en;
            end
            `IPS_OFF_PRIO:
            begin
                rd[PW-1:0] = st_r.prio;
            end
            `IPS_OFF_SRL:
            begin
                rd[`IPS_SRL_LVL_MSB:`IPS_SRL_LVL_LSB] = st_r.cpu_lvl[2:0];
                rd[`IPS_SRL_LOW_MSB:0] = st_r.srl_low;
            end
            `IPS_OFF_TIMED_DISABLE_INSTR:
            begin
                rd[`IPS_TIMED_DISABLE_INSTR_CW-1:0] = timed_disable_instr_left;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase

        // Read data and error are captured in setup so both come from flops.
        if (setup)
        begin
            st_nxt.prdata = rd;
            st_nxt.pslverr = !hit;
        end

        // Writes take effect in the access cycle; pready is always high.
        if (wr_acc)
        begin
            case (apb_req.paddr)
                `IPS_OFF_CTRL1:
                begin
                    st_nxt.nesting_disable = apb_req.pwdata[`IPS_NESTING_DISABLE_BIT];
                    trap_clr = apb_req.pwdata[NTRAP-1:0];
                end
                `IPS_OFF_FLAG:
                begin
                    flag_clr = apb_req.pwdata[NSRC-1:0];
                end
                `IPS_OFF_ENABLE:
                begin
                    st_nxt.en = apb_req.pwdata[NSRC-1:0];
                end
                `IPS_OFF_PRIO:
                begin
                    st_nxt.prio = apb_req.pwdata[PW-1:0];
                end
                `IPS_OFF_SRL:
                begin
                    st_nxt.cpu_lvl[2:0] =
                        apb_req.pwdata[`IPS_SRL_LVL_MSB:`IPS_SRL_LVL_LSB];
                    st_nxt.srl_low = apb_req.pwdata[`IPS_SRL_LOW_MSB:0];
                end
                default:
                begin
                    st_nxt.nesting_disable = st_r.nesting_disable;
                end
            endcase
        end

        // Sticky flags: a new event beats a clear in the same cycle.
        st_nxt.flag = (st_r.flag & ~flag_clr) | src_event;
        st_nxt.trap = (st_r.trap & ~trap_clr) | trap_event;

        // Entry stacks the old level while the stack has room and never touches the flag.
        if (ack_taken)
        begin
            if (st_r.depth < DW'(DEPTH))
            begin
                st_nxt.stack[st_r.depth*FW +: FW] = {st_r.cpu_lvl, st_r.srl_low};
                st_nxt.depth = DW'(st_r.depth + 1'b1);
            end
            st_nxt.cpu_lvl = st_r.pend.level;
            st_nxt.new_cpu_priority_level = st_r.pend.level;
            st_nxt.vec = st_r.pend.code;
        end
        else if (ret_taken)
        begin
            st_nxt.cpu_lvl = frame[FW-1:FW-4];
            st_nxt.srl_low = frame[`IPS_SRL_LOW_MSB:0];
            st_nxt.depth = top_idx;
        end

        // Any register write, entry, return or timed disable start withdraws the offer for one cycle,
        // trading a cycle of latency for never presenting a stale vector.
        event_now = wr_acc || ack_taken || ret_taken || core_cmd.timed_disable_instr;
        st_nxt.pend = best;
        if (event_now)
        begin
            st_nxt.pend.req = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.prio <= {NSRC{`IPS_PRIO_RESET}};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.prdata = st_r.prdata;
    assign apb_rsp.pslverr = st_r.pslverr;
    assign core_req = st_r.pend;
endmodule

// [tb/ips_chk.sv]
// Port assertions of the interrupt priority block.
`timescale 1ns/1ps
module ips_chk #(
    parameter int NSRC  = 8,
    parameter int NTRAP = 4,
    parameter int DEPTH = 8
) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire ips_pkg::ips_apb_req_s  apb_req,
    input wire ips_pkg::ips_apb_rsp_s  apb_rsp,
    input wire logic [NSRC-1:0]        src_event,
    input wire logic [NTRAP-1:0]       trap_event,
    input wire ips_pkg::ips_core_cmd_s core_cmd,
    input wire ips_pkg::ips_core_req_s core_req
);
    import ips_pkg::*;
    // ------------------------------------------------------------
    // Disable window tracker
    // ------------------------------------------------------------
    logic [15:0] left_r;
    logic [15:0] left_nxt;
    logic        quiet;
    // Any of these inputs, or the disable window running out, may change the offer.
    assign quiet = !core_cmd.ack && !core_cmd.ret && !core_cmd.timed_disable_instr && left_r != 16'h0001
        && !(apb_req.psel && apb_req.pwrite) && src_event == '0 && trap_event == '0;
    always_comb
    begin
        left_nxt = left_r;
        if (core_cmd.timed_disable_instr)
            left_nxt = 16'(core_cmd.timed_disable_instr_cnt);
        else if (left_r != 16'h0000)
            left_nxt = left_r - 16'h0001;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            left_r <= 16'h0000;
        else
            left_r <= left_nxt;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_user_lvl;
        core_req.req && !core_req.is_trap |->
            core_req.level inside {[4'h1:4'h7]} && core_req.code < 7'(NSRC);
    endproperty
    a_user_lvl: assert property (p_user_lvl)
        else $error("user offer level out of range");
    property p_trap_lvl;
        core_req.req && core_req.is_trap |-> core_req.level == 4'h8 + 4'(core_req.trap_idx);
    endproperty
    a_trap_lvl: assert property (p_trap_lvl)
        else $error("trap offer level wrong");
    property p_trap;
        trap_event != '0 && !core_req.is_trap |-> ##[1:4] (core_req.req && core_req.is_trap);
    endproperty
    a_trap: assert property (p_trap)
        else $error("trap not offered");
    property p_drop;
        core_req.req && core_cmd.ack |=> !core_req.req;
    endproperty
    a_drop: assert property (p_drop)
        else $error("offer not dropped after take");
    property p_timed_disable_instr;
        left_r != 16'h0000 && core_req.req && !core_req.is_trap |-> core_req.level == 4'h7;
    endproperty
    a_timed_disable_instr: assert property (p_timed_disable_instr)
        else $error("low level offered in disable window");
    property p_stand;
        quiet ##1 (quiet && core_req.req) |=> $stable(core_req);
    endproperty
    a_stand: assert property (p_stand)
        else $error("offer changed without cause");
    property p_nest;
        core_req.req && core_cmd.ack ##1 !core_cmd.ret |=>
            !core_req.req || core_req.level > $past(core_req.level, 2);
    endproperty
    a_nest: assert property (p_nest)
        else $error("offer not above taken level");
    property p_err;
        apb_req.psel && apb_req.penable && apb_req.paddr > 12'h018 |-> apb_rsp.pslverr;
    endproperty
    a_err: assert property (p_err)
        else $error("unmapped access without error");
    c_take: cover property (core_req.req && core_cmd.ack && !core_req.is_trap);
    c_trap: cover property (core_req.req && core_cmd.ack && core_req.is_trap);
    c_timed_disable_instr: cover property (left_r != 16'h0000 && core_req.req);
endmodule

bind ips_top ips_chk #(.NSRC(NSRC), .NTRAP(NTRAP), .DEPTH(DEPTH)) ips_chk_i (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .src_event(src_event), .trap_event(trap_event), .core_cmd(core_cmd), .core_req(core_req));

// [tb/ips_core_model.sv]
// Processor core model that takes offers, returns and starts timed disables.
`timescale 1ns/1ps
module ips_core_model (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire ips_pkg::ips_core_req_s core_req,
    input wire logic                   ack_on,
    input wire logic [1:0]             slow,
    input wire logic                   ret_go,
    input wire logic                   timed_disable_instr_go,
    input wire logic [13:0]            timed_disable_instr_n,
    output ips_pkg::ips_core_cmd_s     core_cmd
);
    import ips_pkg::*;
    logic [1:0] wait_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_cmd <= '0;
            wait_r   <= 2'h0;
        end
        else
        begin
            core_cmd.ret  <= ret_go;
            core_cmd.timed_disable_instr <= timed_disable_instr_go;
            // The count means nothing outside a start pulse, so it wanders.
            core_cmd.timed_disable_instr_cnt <= timed_disable_instr_go ? timed_disable_instr_n : ~core_cmd.timed_disable_instr_cnt;
            core_cmd.ack      <= 1'b0;
            wait_r            <= 2'h0;
            if (ack_on && core_req.req && !core_cmd.ack && !ret_go)
            begin
                core_cmd.ack <= (wait_r == slow);
                wait_r       <= (wait_r == slow) ? 2'h0 : wait_r + 2'h1;
            end
        end
    end
endmodule

// [tb/test_interrupt_priority_status.sv]
// Self-checking bench of the interrupt priority block.
`timescale 1ns/1ps
module test_interrupt_priority_status;
    import ips_pkg::*;
    logic          pclk, presetn, ack_on, ret_go, timed_disable_instr_go;
    logic [1:0]    slow;
    logic [13:0]   timed_disable_instr_n;
    logic [7:0]    src_event;
    logic [3:0]    trap_event;
    logic [31:0]   seed;
    ips_apb_req_s  apb_req;
    ips_apb_rsp_s  apb_rsp;
    ips_core_cmd_s core_cmd;
    ips_core_req_s core_req;
    logic [32:0]   rq[$];
    logic [13:0]   iq[$];
    int            fails, checked;
    ips_top #(.NSRC(8), .NTRAP(4), .DEPTH(8)) ips_top_i (.pclk(pclk), .presetn(presetn),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .src_event(src_event),
        .trap_event(trap_event), .core_cmd(core_cmd), .core_req(core_req));
    ips_core_model ips_core_model_i (.pclk(pclk), .presetn(presetn), .core_req(core_req),
        .ack_on(ack_on), .slow(slow), .ret_go(ret_go), .timed_disable_instr_go(timed_disable_instr_go),
        .timed_disable_instr_n(timed_disable_instr_n), .core_cmd(core_cmd));
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_irq(input ips_core_req_s r, input logic [13:0] exp);
        logic [13:0] got;
        got = {r.is_trap, r.trap_idx, r.code, r.level};
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (apb_rsp.pready !== 1'b1);
        apb_req <= '0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back({1'b0, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic ev(input logic [7:0] s, input logic [3:0] t);
        src_event  <= s;
        trap_event <= t;
        @(posedge pclk);
        src_event  <= '0;
        trap_event <= '0;
        @(posedge pclk);
    endtask
    task automatic take(input logic [13:0] e);
        int n;
        n = 0;
        iq.push_back(e);
        ack_on <= 1'b1;
        while (iq.size() != 0 && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        ack_on <= 1'b0;
        if (n == 200)
            fails++;
        iq.delete();
        @(posedge pclk);
    endtask
    // Any take during the window finds the queue empty and is counted as a failure.
    task automatic hush;
        ack_on <= 1'b1;
        repeat (12) @(posedge pclk);
        ack_on <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic leave;
        ret_go <= 1'b1;
        @(posedge pclk);
        ret_go <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    // ------------------------------------------------------------
    // Result watchers
    // ------------------------------------------------------------
    always @(posedge pclk)
    begin
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1)
            cmp_rd({apb_rsp.pslverr, apb_rsp.prdata}, rq.size() ? rq.pop_front() : 33'h0);
        if (core_cmd.ack === 1'b1 && core_req.req === 1'b1)
        begin
            if (iq.size() == 0)
                fails++;
            else
                cmp_irq(core_req, iq.pop_front());
        end
    end
    initial
    begin
        #800000;
        fails++;
        complete_run;
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        {presetn, ack_on, ret_go, timed_disable_instr_go, slow, timed_disable_instr_n} = '0;
        {src_event, trap_event, apb_req, fails, checked} = '0;
        seed = 32'h66ee79f2;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, 12'h000, 32'hFFFF);
        rd(12'h000, 32'h0);
        rd(12'h010, 32'h924924);
        rd(12'h004, 32'h0);
        rq.push_back(33'h100000000);
        apb(1'b0, 12'h020, 32'h0);
        ev(8'h04, 4'h0);
        rd(12'h008, 32'h4);
        apb(1'b1, 12'h008, 32'h4);
        rd(12'h008, 32'h0);
        apb(1'b1, 12'h010, 32'hB58);
        apb(1'b1, 12'h00C, 32'hF);
        seed = xs(seed);
        apb(1'b1, 12'h014, {27'h0, seed[4:0]});
        ev(8'h0F, 4'h0);
        slow <= 2'h2;
        take(14'h0025);
        rd(12'h000, 32'h0502);
        rd(12'h014, {24'h0, 3'h5, seed[4:0]});
        apb(1'b1, 12'h008, 32'h4);
        leave;
        rd(12'h014, {24'h0, 3'h0, seed[4:0]});
        take(14'h0035);
        apb(1'b1, 12'h008, 32'h8);
        apb(1'b1, 12'h004, 32'h8000);
        leave;
        take(14'h0013);
        ev(8'h04, 4'h0);
        hush;
        leave;
        take(14'h0025);
        apb(1'b1, 12'h008, 32'h4);
        leave;
        take(14'h0013);
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b1, 12'h004, 32'h0);
        leave;
        apb(1'b1, 12'h014, 32'hE0);
        ev(8'h04, 4'h2);
        take(14'h2809);
        rd(12'h000, 32'h0900);
        leave;
        take(14'h2809);
        apb(1'b1, 12'h004, 32'h2);
        rd(12'h004, 32'h0);
        leave;
        hush;
        apb(1'b1, 12'h014, 32'h0);
        take(14'h0025);
        apb(1'b1, 12'h008, 32'h4);
        leave;
        apb(1'b1, 12'h010, 32'hB78);
        timed_disable_instr_n  <= 14'd100;
        timed_disable_instr_go <= 1'b1;
        @(posedge pclk);
        timed_disable_instr_go <= 1'b0;
        ev(8'h06, 4'h0);
        take(14'h0017);
        apb(1'b1, 12'h008, 32'h2);
        leave;
        take(14'h0025);
        apb(1'b1, 12'h008, 32'h4);
        leave;
        complete_run;
    end
endmodule
